// [uart_pkg.sv]
// Constants, bus carrier and state types for the serial transceiver core
package uart_pkg;
    // Clock and baud reference
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
    localparam int BAUD_REF_HZ = 153600;
    localparam int OVERSAMPLE = 16;
    localparam int TICK_REF_HZ = BAUD_REF_HZ * OVERSAMPLE;
    localparam logic [15:0] DL_RESET = 16'h0001;

    // Register offsets
    localparam logic [4:0] OFF_DATA = 5'h11;
    localparam logic [4:0] OFF_IER = 5'h13;
    localparam logic [4:0] OFF_IIR = 5'h15;
    localparam logic [4:0] OFF_LCR = 5'h17;
    localparam logic [4:0] OFF_MCR = 5'h19;
    localparam logic [4:0] OFF_LSR = 5'h1B;
    localparam logic [4:0] OFF_MSR = 5'h1D;

    // Line control fields
    localparam int LC_STOP = 2;
    localparam int LC_PEN = 3;
    localparam int LC_EVEN = 4;
    localparam int LC_STK = 5;
    localparam int LC_BRK = 6;
    localparam int LC_DIVISOR_ACCESS_SELECT = 7;
    localparam int LC_SW_BITS = 6;

    // Modem control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_DRS = 2;
    localparam int MC_SRTS = 3;
    localparam int MC_LOOP = 4;

    // Interrupt enable fields
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_LS = 2;
    localparam int IE_MS = 3;

    // Cause codes, highest first
    localparam logic [1:0] CAUSE_LS = 2'h3;
    localparam logic [1:0] CAUSE_RX = 2'h2;
    localparam logic [1:0] CAUSE_TX = 2'h1;
    localparam logic [1:0] CAUSE_MS = 2'h0;

    // Oversample tick end counts for one bit, half a bit, 1.5 and two stop bits; least last data index
    localparam logic [4:0] BIT_END = 5'h0F;
    localparam logic [4:0] HALF_END = 5'h07;
    localparam logic [4:0] STOP15_END = 5'h17;
    localparam logic [4:0] STOP2_END = 5'h1F;
    localparam logic [2:0] MIN_LAST_IDX = 3'h4;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } modem_t;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PAR = 5'h08,
        TX_STOP = 5'h10
    } tx_state_t;

    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_START = 6'h02,
        RX_DATA = 6'h04,
        RX_PAR = 6'h08,
        RX_STOP = 6'h10,
        RX_HOLD = 6'h20
    } rx_state_t;
endpackage : uart_pkg

// [serial_uart_register_core.sv]
// Serial transceiver core with byte register port, baud generator and interrupt causes
//
// What this block does
// - Offsets 17..29; 17 reads receive, writes transmit
// - Held character moves to empty shifter
// - Assembled character moves to receive buffer
// - Bit rate is 153600 over divisor
// - Divisor access maps 17,19 to divisor
// - Four enable bits, upper zero, reset clears
// - Receive interrupt follows enable and ready flag
// - Transmit interrupt follows empty, cleared by write/ack
// - Line errors interrupt; status read clears
// - Modem deltas interrupt; status read clears
// - Identification gives highest cause as code
// - Identification read freezes cause until cleared
// - Pending bit reads zero while requesting
// - Divisor access bit redirects offsets 17,19
// - Break bit holds transmit line low
// - Line control loads low six switch bits at reset, upper two zero
// - Length code selects five to eight bits
// - Stop field: one, 1.5 or two
// - Stick and even pick parity kind
// - Holding empty clears on write, sets when moved
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module serial_uart_register_core (
    input wire logic mclk,
    input wire logic rst,
    input wire uart_pkg::bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic rxd,
    input wire uart_pkg::modem_t modem_in,
    input wire logic [7:0] line_sw,
    output logic txd,
    output logic dtr,
    output logic rts,
    output logic drs,
    output logic srts,
    output logic irq
);
    import uart_pkg::*;

    // Input synchronisers, second stage is the only reader of the first
    logic rxd_s1, rxd_s2;
    modem_t mdm_s1, mdm_s2;
    logic [7:0] sw_s1, sw_s2;
    always_ff @(posedge mclk) begin
        rxd_s1 <= rxd;
        rxd_s2 <= rxd_s1;
        mdm_s1 <= modem_in;
        mdm_s2 <= mdm_s1;
        sw_s1 <= line_sw;
        sw_s2 <= sw_s1;
    end

    // Register state
    logic [3:0] ier_q, ier_d;
    logic [7:0] lcr_q, lcr_d;
    logic [4:0] mcr_q, mcr_d;
    logic [15:0] dl_q, dl_d;
    logic [7:0] thr_q, thr_d, rbr_q, rbr_d, rdata_q, rdata_d;
    logic tx_holding_empty_q, tx_holding_empty_d, dr_q, dr_d, thack_q, thack_d, frz_q, frz_d;
    logic [3:0] err_q, err_d, mdelta_q, mdelta_d;
    logic [1:0] frz_code_q, frz_code_d;
    modem_t m_prev_q, m_now;
    logic txd_q, txd_d, irq_q;

    logic divisor_access_select, loop_on, tsre, tx_load, rx_done, rx_in, tick;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic [3:0] rx_err, cause;
    logic [1:0] live_code, shown_code;
    logic pend, rd_rbr;

    assign divisor_access_select = lcr_q[LC_DIVISOR_ACCESS_SELECT];
    assign loop_on = mcr_q[MC_LOOP];

    // Parity bit for the selected kind over the active data bits
    // parity kind select
    function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
        logic [7:0] m;
        m = 8'hFF >> (2'h3 - lc[1:0]);
        if (lc[LC_STK]) begin
            par_of = ~lc[LC_EVEN];
        end else begin
            par_of = lc[LC_EVEN] ? ^(d & m) : ~^(d & m);
        end
    endfunction : par_of

    // last data bit index from length code
    function automatic logic [2:0] last_idx(input logic [7:0] lc);
        last_idx = MIN_LAST_IDX + {1'b0, lc[1:0]};
    endfunction : last_idx

    // Baud generator: fractional prescale to 16x reference, then divisor
    logic [24:0] acc_q, acc_d;
    logic [15:0] div_cnt_q, div_cnt_d;
    logic [24:0] acc_sum;
    always_comb begin
        acc_sum = acc_q + 25'(TICK_REF_HZ);
        acc_d = acc_sum;
        div_cnt_d = div_cnt_q;
        tick = 1'b0;
        if (acc_sum >= 25'(CLK_HZ)) begin
            acc_d = acc_sum - 25'(CLK_HZ);
            if (dl_q != 16'h0000) begin
                if (div_cnt_q + 16'h0001 >= dl_q) begin
                    div_cnt_d = 16'h0000;
                    tick = 1'b1;
                end else begin
                    div_cnt_d = div_cnt_q + 16'h0001;
                end
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_q <= 25'h0000000;
            div_cnt_q <= 16'h0000;
        end else begin
            acc_q <= acc_d;
            div_cnt_q <= div_cnt_d;
        end
    end

    // Transmitter
    tx_state_t tx_st_q, tx_st_d;
    logic [4:0] tx_cnt_q, tx_cnt_d;
    logic [2:0] tx_idx_q, tx_idx_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic tx_line_q, tx_line_d, tx_par_q, tx_par_d;
    logic [4:0] stop_end;
    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tick ? tx_cnt_q + 5'h01 : tx_cnt_q;
        tx_idx_d = tx_idx_q;
        tx_sh_d = tx_sh_q;
        tx_line_d = tx_line_q;
        tx_par_d = tx_par_q;
        tx_load = 1'b0;
        if (!lcr_q[LC_STOP]) begin
            stop_end = BIT_END;
        end else begin
            stop_end = (lcr_q[1:0] == 2'h0) ? STOP15_END : STOP2_END;
        end
        unique case (tx_st_q)
            TX_IDLE: begin
                tx_line_d = 1'b1;
                if (!tx_holding_empty_q) begin
                    tx_load = 1'b1;
                    tx_sh_d = thr_q;
                    tx_par_d = par_of(thr_q, lcr_q);
                    tx_cnt_d = 5'h00;
                    tx_line_d = 1'b0;
                    tx_st_d = TX_START;
                end
            end
            TX_START: begin
                if (tick && tx_cnt_q == BIT_END) begin
                    tx_cnt_d = 5'h00;
                    tx_idx_d = 3'h0;
                    tx_line_d = tx_sh_q[0];
                    tx_st_d = TX_DATA;
                end
            end
            TX_DATA: begin
                // data LSB first, then parity or stop
                if (tick && tx_cnt_q == BIT_END) begin
                    tx_cnt_d = 5'h00;
                    if (tx_idx_q == last_idx(lcr_q)) begin
                        tx_line_d = lcr_q[LC_PEN] ? tx_par_q : 1'b1;
                        tx_st_d = lcr_q[LC_PEN] ? TX_PAR : TX_STOP;
                    end else begin
                        tx_idx_d = tx_idx_q + 3'h1;
                        tx_sh_d = tx_sh_q >> 1;
                        tx_line_d = tx_sh_q[1];
                    end
                end
            end
            TX_PAR: begin
                if (tick && tx_cnt_q == BIT_END) begin
                    tx_cnt_d = 5'h00;
                    tx_line_d = 1'b1;
                    tx_st_d = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tick && tx_cnt_q == stop_end) begin
                    tx_st_d = TX_IDLE;
                end
            end
        endcase
        // break overrides; loop keeps the pin marking
        txd_d = lcr_q[LC_BRK] ? 1'b0 : (loop_on ? 1'b1 : tx_line_q);
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= 5'h00;
            tx_idx_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_line_q <= 1'b1;
            tx_par_q <= 1'b0;
            txd_q <= 1'b1;
        end else begin
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_idx_q <= tx_idx_d;
            tx_sh_q <= tx_sh_d;
            tx_line_q <= tx_line_d;
            tx_par_q <= tx_par_d;
            txd_q <= txd_d;
        end
    end
    assign tsre = (tx_st_q == TX_IDLE);

    // Receiver, sampling mid-bit on the 16x tick
    rx_state_t rx_st_q, rx_st_d;
    logic [4:0] rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_idx_q, rx_idx_d;
    logic rx_par_q, rx_par_d;
    assign rx_in = loop_on ? tx_line_q : rxd_s2;
    always_comb begin
        rx_st_d = rx_st_q;
        rx_cnt_d = tick ? rx_cnt_q + 5'h01 : rx_cnt_q;
        rx_idx_d = rx_idx_q;
        rx_sh_d = rx_sh_q;
        rx_par_d = rx_par_q;
        rx_done = 1'b0;
        rx_err = 4'h0;
        unique case (rx_st_q)
            RX_IDLE: begin
                rx_cnt_d = 5'h00;
                if (!rx_in) begin
                    rx_st_d = RX_START;
                end
            end
            RX_START: begin
                // Recheck at mid start bit so glitches are dropped
                if (tick && rx_cnt_q == HALF_END) begin
                    rx_cnt_d = 5'h00;
                    rx_idx_d = 3'h0;
                    rx_sh_d = 8'h00;
                    rx_st_d = rx_in ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (tick && rx_cnt_q == BIT_END) begin
                    rx_cnt_d = 5'h00;
                    rx_sh_d[rx_idx_q] = rx_in;
                    if (rx_idx_q == last_idx(lcr_q)) begin
                        rx_st_d = lcr_q[LC_PEN] ? RX_PAR : RX_STOP;
                    end else begin
                        rx_idx_d = rx_idx_q + 3'h1;
                    end
                end
            end
            RX_PAR: begin
                if (tick && rx_cnt_q == BIT_END) begin
                    rx_cnt_d = 5'h00;
                    rx_par_d = rx_in;
                    rx_st_d = RX_STOP;
                end
            end
            RX_STOP: begin
                if (tick && rx_cnt_q == BIT_END) begin
                    rx_done = 1'b1;
                    rx_err[3] = (rx_sh_q == 8'h00) && !rx_in && !(lcr_q[LC_PEN] && rx_par_q);
                    rx_err[2] = !rx_in;
                    rx_err[1] = lcr_q[LC_PEN] && (rx_par_q != par_of(rx_sh_q, lcr_q));
                    rx_st_d = rx_in ? RX_IDLE : RX_HOLD;
                end
            end
            RX_HOLD: begin
                // Wait out a break before hunting for a new start bit
                if (rx_in) begin
                    rx_st_d = RX_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= 5'h00;
            rx_idx_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_par_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_idx_q <= rx_idx_d;
            rx_sh_q <= rx_sh_d;
            rx_par_q <= rx_par_d;
        end
    end

    // Interrupt causes, indexed by cause code
    // cause terms
    assign cause[CAUSE_LS] = ier_q[IE_LS] && (|err_q);
    assign cause[CAUSE_RX] = ier_q[IE_RX] && dr_q;
    assign cause[CAUSE_TX] = ier_q[IE_TX] && tx_holding_empty_q && !thack_q;
    assign cause[CAUSE_MS] = ier_q[IE_MS] && (|mdelta_q);
    assign pend = |cause;
    assign live_code = cause[CAUSE_LS] ? CAUSE_LS : cause[CAUSE_RX] ? CAUSE_RX :
                       cause[CAUSE_TX] ? CAUSE_TX : CAUSE_MS;
    assign shown_code = frz_q ? frz_code_q : live_code;
    assign m_now = loop_on ? modem_t'({mcr_q[MC_DRS], mcr_q[MC_SRTS], mcr_q[MC_DTR],
                                       mcr_q[MC_RTS]}) : mdm_s2;
    assign rd_rbr = bus.rd && bus.addr == OFF_DATA && !divisor_access_select;

    // Register file: load flag before reads and writes, receive and modem events last so their sets win
    always_comb begin
        ier_d = ier_q;
        lcr_d = lcr_q;
        mcr_d = mcr_q;
        dl_d = dl_q;
        thr_d = thr_q;
        tx_holding_empty_d = tx_holding_empty_q;
        rbr_d = rbr_q;
        dr_d = dr_q;
        err_d = err_q;
        mdelta_d = mdelta_q;
        thack_d = thack_q;
        frz_d = frz_q;
        frz_code_d = frz_code_q;
        rdata_d = 8'h00;
        // frozen cause released once its condition is gone
        if (frz_q && !cause[frz_code_q]) begin
            frz_d = 1'b0;
        end
        if (tx_load) begin
            tx_holding_empty_d = 1'b1;
        end
        if (bus.rd) begin
            case (bus.addr)
                OFF_DATA: begin
                    rdata_d = divisor_access_select ? dl_q[7:0] : rbr_q;
                    if (!divisor_access_select) begin
                        dr_d = 1'b0;
                    end
                end
                OFF_IER: rdata_d = divisor_access_select ? dl_q[15:8] : {4'h0, ier_q};
                OFF_IIR: begin
                    rdata_d = {5'h00, shown_code, ~pend};
                    if (pend && !frz_q) begin
                        frz_d = 1'b1;
                        frz_code_d = live_code;
                    end
                    if (pend && shown_code == CAUSE_TX) begin
                        thack_d = 1'b1;
                    end
                end
                OFF_LCR: rdata_d = lcr_q;
                OFF_MCR: rdata_d = {3'h0, mcr_q};
                OFF_LSR: begin
                    rdata_d = {1'b0, tsre, tx_holding_empty_q, err_q, dr_q};
                    err_d = 4'h0;
                end
                OFF_MSR: begin
                    rdata_d = {m_now, mdelta_q};
                    mdelta_d = 4'h0;
                end
                default: rdata_d = 8'h00;
            endcase
        end
        if (bus.wr) begin
            case (bus.addr)
                OFF_DATA: begin
                    if (divisor_access_select) begin
                        dl_d[7:0] = bus.wdata;
                    end else begin
                        thr_d = bus.wdata;
                        tx_holding_empty_d = 1'b0;
                    end
                end
                OFF_IER: begin
                    if (divisor_access_select) begin
                        dl_d[15:8] = bus.wdata;
                    end else begin
                        ier_d = bus.wdata[3:0];
                    end
                end
                OFF_LCR: lcr_d = bus.wdata;
                OFF_MCR: mcr_d = bus.wdata[4:0];
                OFF_LSR: begin
                    dr_d = bus.wdata[0];
                    err_d = err_q | bus.wdata[4:1];
                    tx_holding_empty_d = tx_holding_empty_d | bus.wdata[5];
                end
                default: ;
            endcase
        end
        // acknowledge ends once the holding register refills
        if (!tx_holding_empty_d) begin
            thack_d = 1'b0;
        end
        if (rx_done) begin
            rbr_d = rx_sh_q;
            dr_d = 1'b1;
            err_d = err_d | {rx_err[3:1], dr_q && !rd_rbr};
        end
        // deltas from the synchronised modem lines, or from the control bits in loopback
        mdelta_d[3] = mdelta_d[3] | (m_now.cd ^ m_prev_q.cd);
        mdelta_d[2] = mdelta_d[2] | (m_prev_q.ri & ~m_now.ri);
        mdelta_d[1] = mdelta_d[1] | (m_now.dsr ^ m_prev_q.dsr);
        mdelta_d[0] = mdelta_d[0] | (m_now.cts ^ m_prev_q.cts);
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ier_q <= 4'h0;
            lcr_q <= {2'h0, sw_s2[LC_SW_BITS-1:0]};
            mcr_q <= 5'h00;
            dl_q <= DL_RESET;
            thr_q <= 8'h00;
            tx_holding_empty_q <= 1'b1;
            rbr_q <= 8'h00;
            dr_q <= 1'b0;
            err_q <= 4'h0;
            mdelta_q <= 4'h0;
            thack_q <= 1'b0;
            frz_q <= 1'b0;
            frz_code_q <= CAUSE_MS;
            rdata_q <= 8'h00;
            m_prev_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            ier_q <= ier_d;
            lcr_q <= lcr_d;
            mcr_q <= mcr_d;
            dl_q <= dl_d;
            thr_q <= thr_d;
            tx_holding_empty_q <= tx_holding_empty_d;
            rbr_q <= rbr_d;
            dr_q <= dr_d;
            err_q <= err_d;
            mdelta_q <= mdelta_d;
            thack_q <= thack_d;
            frz_q <= frz_d;
            frz_code_q <= frz_code_d;
            rdata_q <= rdata_d;
            m_prev_q <= m_now;
            irq_q <= pend;
        end
    end

    assign rdata = rdata_q;
    assign txd = txd_q;
    assign irq = irq_q;
    assign dtr = mcr_q[MC_DTR];
    assign rts = mcr_q[MC_RTS];
    assign drs = mcr_q[MC_DRS];
    assign srts = mcr_q[MC_SRTS];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence tx_launch_s;
        tsre && !tx_holding_empty_q && !lcr_q[LC_BRK] && !loop_on;
    endsequence
    sequence tx_start_low_s;
        ##2 (txd_q == 1'b0);
    endsequence

    tx_start_bit_a: assert property (tx_launch_s |-> tx_start_low_s)
        else $error("start bit not driven low");
    tx_handoff_a: assert property (tsre && !tx_holding_empty_q && !bus.wr |=> tx_holding_empty_q && !tsre)
        else $error("held character not moved to shifter");
    break_hold_a: assert property (lcr_q[LC_BRK] |=> txd_q == 1'b0)
        else $error("break did not hold line low");
    rx_transfer_a: assert property (rx_done |=> dr_q && rbr_q == $past(rx_sh_q))
        else $error("character not moved to receive buffer");
    thr_write_a: assert property (bus.wr && bus.addr == OFF_DATA && !divisor_access_select |=> !tx_holding_empty_q)
        else $error("holding empty not cleared by write");
    // A load in the same cycle may still empty the holding register
    div_route_a: assert property (bus.wr && bus.addr == OFF_DATA && divisor_access_select
        |=> dl_q[7:0] == $past(bus.wdata) && (tx_holding_empty_q == $past(tx_holding_empty_q) || $past(tx_load)))
        else $error("divisor write reached data path");
    ier_read_a: assert property (bus.rd && bus.addr == OFF_IER && !divisor_access_select
        |=> rdata[7:4] == 4'h0 && rdata[3:0] == $past(ier_q))
        else $error("enable register read wrong");
    lsr_clear_a: assert property (bus.rd && bus.addr == OFF_LSR && !rx_done
        |=> err_q == 4'h0 && !cause[CAUSE_LS])
        else $error("line status read did not clear errors");
    iir_pending_a: assert property (bus.rd && bus.addr == OFF_IIR
        |=> rdata[0] == !$past(pend) && rdata[2:1] == $past(shown_code))
        else $error("identification read wrong");
    freeze_hold_a: assert property (bus.rd && bus.addr == OFF_IIR && pend && !frz_q
        |=> frz_q && frz_code_q == $past(live_code))
        else $error("cause not frozen on read");
    irq_follow_a: assert property (##1 irq == $past(pend))
        else $error("interrupt output not following causes");
endmodule : serial_uart_register_core
`default_nettype wire

// [serial_term_model.sv]
// Terminal on the serial line: raw frame sender and 8N1 receiver
`timescale 1ns/10ps
`default_nettype none
module serial_term_model #(parameter real BIT_NS = 6510.4) (
    input wire logic txd,
    output logic rxd,
    output logic [7:0] got,
    output logic got_stb
);
    initial begin
        rxd = 1'b1;
        got = 8'h00;
        got_stb = 1'b0;
    end
    // caller builds the frame, bits go LSB first
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd = f[i];
            #(BIT_NS);
        end
    endtask : send
    always begin
        @(negedge txd);
        #(BIT_NS / 2);
        // Short low pulse is no start
        if (txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                #(BIT_NS);
                got[i] = txd;
            end
            #(BIT_NS);
            got_stb = txd;
            #(BIT_NS / 4);
            got_stb = 1'b0;
        end
    end
endmodule : serial_term_model
`default_nettype wire

// [tb_serial_uart_register_core.sv]
// Self-checking bench for the serial transceiver register core
`timescale 1ns/10ps
`default_nettype none
module tb_serial_uart_register_core;
    import uart_pkg::*;
    logic mclk, rst, rxd, txd, irq, t_stb;
    logic rd_seen = 1'b0;
    bus_req_t bus;
    modem_t modem_in;
    logic [7:0] rdata, line_sw, t_got, b;
    logic [3:0] mc_out;
    logic [31:0] seed = 32'h0A14;
    logic [7:0] rq[$], sq[$];
    int fails = 0, n_checks = 0;
    serial_uart_register_core i_dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
        .rxd(rxd), .modem_in(modem_in), .line_sw(line_sw), .txd(txd), .dtr(mc_out[0]),
        .rts(mc_out[1]), .drs(mc_out[2]), .srts(mc_out[3]), .irq(irq));
    serial_term_model i_term (.txd(txd), .rxd(rxd), .got(t_got), .got_stb(t_stb));
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // Read notes its expected value d
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{rd: !w, wr: w, addr: a, wdata: w ? d : 8'h00};
        if (!w) rq.push_back(d);
        @(posedge mclk);
        bus <= '0;
    endtask : acc
    // Lands past the edge so registered outputs have settled
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask : idle
    task automatic test_done();
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    always @(posedge mclk) begin
        if (rd_seen) cmp(rdata, rq.pop_front());
        rd_seen <= bus.rd;
    end
    always @(posedge t_stb) cmp(t_got, sq.pop_front());
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        #3000000;
        fails++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        bus = '0;
        modem_in = '0;
        line_sw = xs();
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        acc(0, OFF_LCR, {2'b00, line_sw[5:0]});
        acc(0, OFF_IER, 8'h00);
        acc(0, OFF_IIR, 8'h01);
        acc(1, OFF_LCR, 8'h03);
        acc(1, OFF_IER, 8'hFF);
        acc(0, OFF_IER, 8'h0F);
        idle(2);
        cmp({7'h00, irq}, 8'h01);
        acc(0, OFF_IIR, 8'h02);
        acc(0, OFF_IIR, 8'h01);
        idle(3);
        cmp({7'h00, irq}, 8'h00);
        acc(1, OFF_LCR, 8'h83);
        b = xs();
        acc(1, OFF_DATA, b);
        acc(1, OFF_IER, ~b);
        acc(0, OFF_DATA, b);
        acc(0, OFF_IER, ~b);
        acc(0, OFF_LCR, 8'h83);
        acc(1, OFF_DATA, 8'h01);
        acc(1, OFF_IER, 8'h00);
        acc(1, OFF_LCR, 8'h03);
        acc(0, OFF_IER, 8'h0F);
        acc(1, OFF_IER, 8'h00);
        repeat (2) begin
            b = xs();
            sq.push_back(b);
            acc(1, OFF_DATA, b);
            idle(20);
        end
        acc(0, OFF_LSR, 8'h00);
        for (int i = 0; i < 4000 && sq.size() != 0; i++) @(posedge mclk);
        cmp(8'(sq.size()), 8'h00);
        idle(100);
        acc(0, OFF_LSR, 8'h60);
        acc(1, OFF_LCR, 8'h43);
        idle(3);
        cmp({7'h00, txd}, 8'h00);
        acc(1, OFF_LCR, 8'h03);
        acc(1, OFF_IER, 8'h05);
        b = xs();
        i_term.send({3'b111, b, 1'b0}, 10);
        idle(20);
        acc(0, OFF_LSR, 8'h61);
        acc(0, OFF_IIR, 8'h04);
        acc(0, OFF_DATA, b);
        acc(0, OFF_IIR, 8'h01);
        repeat (2) i_term.send({3'b111, xs(), 1'b0}, 10);
        idle(20);
        acc(0, OFF_IIR, 8'h06);
        acc(0, OFF_LSR, 8'h63);
        acc(0, OFF_IIR, 8'h04);
        acc(1, OFF_LSR, 8'h00);
        acc(0, OFF_LSR, 8'h60);
        // Seven bits, even parity, sent with the wrong parity bit
        acc(1, OFF_LCR, 8'h1A);
        b = xs();
        i_term.send({3'b111, ~^b[6:0], b[6:0], 1'b0}, 10);
        idle(20);
        acc(0, OFF_LSR, 8'h65);
        acc(0, OFF_DATA, {1'b0, b[6:0]});
        acc(1, OFF_LCR, 8'h03);
        acc(1, OFF_IER, 8'h08);
        @(posedge mclk);
        modem_in.cts <= 1'b1;
        idle(8);
        cmp({7'h00, irq}, 8'h01);
        acc(0, OFF_IIR, 8'h00);
        acc(0, OFF_MSR, 8'h11);
        acc(0, OFF_IIR, 8'h01);
        // Loopback feeds modem status from the control outputs
        acc(1, OFF_MCR, 8'h1F);
        idle(1);
        cmp({4'h0, mc_out}, 8'h0F);
        acc(0, OFF_MCR, 8'h1F);
        acc(0, OFF_MSR, 8'hFA);
        acc(1, 5'h01, 8'hFF);
        acc(0, 5'h1F, 8'h00);
        idle(3);
        test_done();
    end
endmodule : tb_serial_uart_register_core
`default_nettype wire
